/* cie_gate.sv */
// can interrupt enable register and request gating
// Summary of operation
// - doze-entry request while enable bit 17 and doze-entry flag both set.
// - doze-exit request while enable bit 16 and doze-exit flag both set.
// - error request while enable bit 15 and summary error flag both set.
// - hardware error type update sets summary error only with bit 11.
// - bus-off rising sets summary error only with bit 10.
// - error-passive rising sets summary error only with bit 9.
// - error-warning rising sets summary error only with bit 8.
// - fifo 1 overflow request needs bit 6 and its flag.
// - fifo 1 full request needs bit 5 and its flag.
// - fifo 1 message request needs bit 4 and nonzero count.
// - fifo 0 overflow request needs bit 3 and its flag.
// - fifo 0 full request needs bit 2 and its flag.
// - fifo 0 message request needs bit 1 and nonzero count.
// - mailbox empty request needs bit 0 and any tx-complete flag.
// - fifo full flag sets when three messages are pending.
// - bus-off indication sets when transmit error count exceeds 255.
`timescale 1ns/1ps
`default_nettype none
module cie_gate (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [7:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr_en,
  input  wire logic            rd_en,
  output var  logic [31:0]     rdata,
  input  wire cie_pkg::cie_evt_s evt,
  output var  logic [9:0]      irq_req,
  output var  logic            irq
);
  import cie_pkg::*;

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [31:0] can_irq_enable;
  logic [CIE_NREQ-1:0] stat;
  logic [CIE_NREQ-1:0] mask;
  logic [CIE_NREQ-1:0] next_req;
  logic        summary_error_flag;
  logic        fifo0_full_flag;
  logic        fifo1_full_flag;
  logic        bus_off_indication;
  logic        prev_boff;
  logic        prev_epas;
  logic        prev_ewarn;
  logic        err_set;
  logic        wr_en_reg;
  logic        wr_flags;

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign wr_en_reg = wr_en && (addr == CIE_ENABLE_OFS);
  assign wr_flags  = wr_en && (addr == CIE_FLAGS_OFS);

  // enable register, reserved bits held at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      can_irq_enable <= CIE_ENABLE_RST;
    end else if (wr_en_reg) begin
      can_irq_enable <= wdata & CIE_ENABLE_WMASK;
    end
  end

  // bus-off from transmit error count
  assign bus_off_indication = evt.transmit_error_count > CIE_BOFF_LIMIT;

  // edge history of error state indications
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_boff  <= 1'b0;
      prev_epas  <= 1'b0;
      prev_ewarn <= 1'b0;
    end else begin
      prev_boff  <= bus_off_indication;
      prev_epas  <= evt.error_passive_indication;
      prev_ewarn <= evt.error_warning_indication;
    end
  end

  // qualified error events feeding summary error flag
  always_comb begin
    err_set = 1'b0;
    if (evt.error_type_hw_wr && evt.error_type_field != CIE_ETR_NONE && can_irq_enable[CIE_B_ETR]) begin
      err_set = 1'b1;
    end
    if (bus_off_indication && !prev_boff && can_irq_enable[CIE_B_BOFF]) begin
      err_set = 1'b1;
    end
    if (evt.error_passive_indication && !prev_epas && can_irq_enable[CIE_B_EPAS]) begin
      err_set = 1'b1;
    end
    if (evt.error_warning_indication && !prev_ewarn && can_irq_enable[CIE_B_EWARN]) begin
      err_set = 1'b1;
    end
  end

  // summary error flag, cleared by writing one to bit 0 of flags register
  cie_rw1c_bit u_err_flag (
    .clk (clk),
    .rst_n (rst_n),
    .set (err_set),
    .clr (wr_flags && wdata[0]),
    .q (summary_error_flag)
  );

  // fifo full flags at three pending messages
  cie_rw1c_bit u_f0_full (
    .clk (clk),
    .rst_n (rst_n),
    .set (evt.fifo0_msg_count == CIE_FIFO_FULL_CNT),
    .clr (wr_flags && wdata[1]),
    .q (fifo0_full_flag)
  );
  cie_rw1c_bit u_f1_full (
    .clk (clk),
    .rst_n (rst_n),
    .set (evt.fifo1_msg_count == CIE_FIFO_FULL_CNT),
    .clr (wr_flags && wdata[2]),
    .q (fifo1_full_flag)
  );

  // gated request levels
  always_comb begin
    next_req = '0;
    next_req[CIE_R_DZ_IN]  = can_irq_enable[CIE_B_DZ_IN] && evt.doze_entry_flag;
    next_req[CIE_R_DZ_OUT] = can_irq_enable[CIE_B_DZ_OUT] && evt.doze_exit_flag;
    next_req[CIE_R_ERR]    = can_irq_enable[CIE_B_ERR] && summary_error_flag;
    next_req[CIE_R_F1OV]   = can_irq_enable[CIE_B_F1OV] && evt.fifo1_overflow_flag;
    next_req[CIE_R_F1FU]   = can_irq_enable[CIE_B_F1FU] && fifo1_full_flag;
    next_req[CIE_R_F1MSG]  = can_irq_enable[CIE_B_F1MSG] && (evt.fifo1_msg_count != 2'h0);
    next_req[CIE_R_F0OV]   = can_irq_enable[CIE_B_F0OV] && evt.fifo0_overflow_flag;
    next_req[CIE_R_F0FU]   = can_irq_enable[CIE_B_F0FU] && fifo0_full_flag;
    next_req[CIE_R_F0MSG]  = can_irq_enable[CIE_B_F0MSG] && (evt.fifo0_msg_count != 2'h0);
    next_req[CIE_R_TXE]    = can_irq_enable[CIE_B_TXE] && (|evt.mailbox_tx_complete_flag);
  end

  // registered request levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= next_req;
    end
  end

  // sticky status per request rise, w1c, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~((wr_en && addr == CIE_STATUS_OFS) ? wdata[CIE_NREQ-1:0] : '0)) | (next_req & ~irq_req);
    end
  end

  // interrupt mask register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (wr_en && addr == CIE_MASK_OFS) begin
      mask <= wdata[CIE_NREQ-1:0];
    end
  end

  // single level interrupt output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  // read data one cycle after read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        CIE_ENABLE_OFS: rdata <= can_irq_enable;
        CIE_STATUS_OFS: rdata <= {22'h0, stat};
        CIE_MASK_OFS:   rdata <= {22'h0, mask};
        CIE_FLAGS_OFS:  rdata <= {28'h0, bus_off_indication, fifo1_full_flag, fifo0_full_flag, summary_error_flag};
        default:        rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  property p_dz_in;
    @(posedge clk) disable iff (!rst_n)
      (can_irq_enable[CIE_B_DZ_IN] && evt.doze_entry_flag) |=> irq_req[CIE_R_DZ_IN];
  endproperty
  a_dz_in: assert property (p_dz_in) else $error("doze entry request missing");

  property p_dz_out;
    @(posedge clk) disable iff (!rst_n)
      irq_req[CIE_R_DZ_OUT] |-> $past(can_irq_enable[CIE_B_DZ_OUT]) && $past(evt.doze_exit_flag);
  endproperty
  a_dz_out: assert property (p_dz_out) else $error("doze exit request without cause");

  property p_err;
    @(posedge clk) disable iff (!rst_n)
      irq_req[CIE_R_ERR] |-> $past(summary_error_flag) && $past(can_irq_enable[CIE_B_ERR]);
  endproperty
  a_err: assert property (p_err) else $error("error request without cause");

  property p_err_qual;
    @(posedge clk) disable iff (!rst_n)
      $rose(summary_error_flag) |-> $past(can_irq_enable[CIE_B_ETR]) || $past(can_irq_enable[CIE_B_BOFF])
        || $past(can_irq_enable[CIE_B_EPAS]) || $past(can_irq_enable[CIE_B_EWARN]);
  endproperty
  a_err_qual: assert property (p_err_qual) else $error("summary error set while all sources disabled");

  property p_boff;
    @(posedge clk) disable iff (!rst_n)
      ($rose(bus_off_indication) && can_irq_enable[CIE_B_BOFF]) |=> summary_error_flag;
  endproperty
  a_boff: assert property (p_boff) else $error("bus-off did not set summary error");

  property p_f0msg;
    @(posedge clk) disable iff (!rst_n)
      (can_irq_enable[CIE_B_F0MSG] && evt.fifo0_msg_count != 2'h0) |=> irq_req[CIE_R_F0MSG];
  endproperty
  a_f0msg: assert property (p_f0msg) else $error("fifo 0 message request missing");

  property p_txe;
    @(posedge clk) disable iff (!rst_n)
      !can_irq_enable[CIE_B_TXE] |=> !irq_req[CIE_R_TXE];
  endproperty
  a_txe: assert property (p_txe) else $error("mailbox request while disabled");

  sequence s_full;
    evt.fifo1_msg_count == CIE_FIFO_FULL_CNT;
  endsequence
  property p_full;
    @(posedge clk) disable iff (!rst_n)
      s_full |=> fifo1_full_flag;
  endproperty
  a_full: assert property (p_full) else $error("fifo 1 full flag not set");

  property p_drop;
    @(posedge clk) disable iff (!rst_n)
      $fell(can_irq_enable[CIE_B_F1OV]) |=> !irq_req[CIE_R_F1OV];
  endproperty
  a_drop: assert property (p_drop) else $error("request held after enable cleared");

  property p_etr;
    @(posedge clk) disable iff (!rst_n)
      (evt.error_type_hw_wr && evt.error_type_field != CIE_ETR_NONE && can_irq_enable[CIE_B_ETR]) |=> summary_error_flag;
  endproperty
  a_etr: assert property (p_etr) else $error("error type update did not set summary error");

  sequence s_epas_rise;
    $rose(evt.error_passive_indication) && can_irq_enable[CIE_B_EPAS];
  endsequence
  property p_epas;
    @(posedge clk) disable iff (!rst_n)
      s_epas_rise |=> summary_error_flag;
  endproperty
  a_epas: assert property (p_epas) else $error("error passive did not set summary error");

  sequence s_ewarn_rise;
    $rose(evt.error_warning_indication) && can_irq_enable[CIE_B_EWARN];
  endsequence
  property p_ewarn;
    @(posedge clk) disable iff (!rst_n)
      s_ewarn_rise |=> summary_error_flag;
  endproperty
  a_ewarn: assert property (p_ewarn) else $error("error warning did not set summary error");

  property p_f1ov;
    @(posedge clk) disable iff (!rst_n)
      (can_irq_enable[CIE_B_F1OV] && evt.fifo1_overflow_flag) |=> irq_req[CIE_R_F1OV];
  endproperty
  a_f1ov: assert property (p_f1ov) else $error("fifo 1 overflow request missing");

  property p_f1fu;
    @(posedge clk) disable iff (!rst_n)
      irq_req[CIE_R_F1FU] |-> $past(fifo1_full_flag) && $past(can_irq_enable[CIE_B_F1FU]);
  endproperty
  a_f1fu: assert property (p_f1fu) else $error("fifo 1 full request without cause");

  property p_f1msg;
    @(posedge clk) disable iff (!rst_n)
      (can_irq_enable[CIE_B_F1MSG] && evt.fifo1_msg_count != 2'h0) |=> irq_req[CIE_R_F1MSG];
  endproperty
  a_f1msg: assert property (p_f1msg) else $error("fifo 1 message request missing");

  property p_f0ov;
    @(posedge clk) disable iff (!rst_n)
      (can_irq_enable[CIE_B_F0OV] && evt.fifo0_overflow_flag) |=> irq_req[CIE_R_F0OV];
  endproperty
  a_f0ov: assert property (p_f0ov) else $error("fifo 0 overflow request missing");

  property p_f0fu;
    @(posedge clk) disable iff (!rst_n)
      irq_req[CIE_R_F0FU] |-> $past(fifo0_full_flag) && $past(can_irq_enable[CIE_B_F0FU]);
  endproperty
  a_f0fu: assert property (p_f0fu) else $error("fifo 0 full request without cause");
endmodule
`default_nettype wire

/* cie_pkg.sv */
// package for the can interrupt enable and gating block
package cie_pkg;
  // register byte offsets
  localparam logic [7:0]  CIE_ENABLE_OFS   = 8'h00;
  localparam logic [7:0]  CIE_STATUS_OFS   = 8'h04;
  localparam logic [7:0]  CIE_MASK_OFS     = 8'h08;
  localparam logic [7:0]  CIE_FLAGS_OFS    = 8'h0C;
  // enable register writable bits and reset value
  localparam logic [31:0] CIE_ENABLE_WMASK = 32'h0003_8F7F;
  localparam logic [31:0] CIE_ENABLE_RST   = 32'h0000_0000;
  // enable bit positions
  localparam int CIE_B_DZ_IN  = 17;
  localparam int CIE_B_DZ_OUT = 16;
  localparam int CIE_B_ERR    = 15;
  localparam int CIE_B_ETR    = 11;
  localparam int CIE_B_BOFF   = 10;
  localparam int CIE_B_EPAS   = 9;
  localparam int CIE_B_EWARN  = 8;
  localparam int CIE_B_F1OV   = 6;
  localparam int CIE_B_F1FU   = 5;
  localparam int CIE_B_F1MSG  = 4;
  localparam int CIE_B_F0OV   = 3;
  localparam int CIE_B_F0FU   = 2;
  localparam int CIE_B_F0MSG  = 1;
  localparam int CIE_B_TXE    = 0;
  // request vector positions
  localparam int CIE_NREQ     = 10;
  localparam int CIE_R_TXE    = 0;
  localparam int CIE_R_F0MSG  = 1;
  localparam int CIE_R_F0FU   = 2;
  localparam int CIE_R_F0OV   = 3;
  localparam int CIE_R_F1MSG  = 4;
  localparam int CIE_R_F1FU   = 5;
  localparam int CIE_R_F1OV   = 6;
  localparam int CIE_R_ERR    = 7;
  localparam int CIE_R_DZ_OUT = 8;
  localparam int CIE_R_DZ_IN  = 9;
  // fifo full threshold, bus-off threshold
  localparam logic [1:0]  CIE_FIFO_FULL_CNT = 2'h3;
  localparam logic [8:0]  CIE_BOFF_LIMIT    = 9'h0FF;
  localparam logic [2:0]  CIE_ETR_NONE      = 3'h0;
  // incoming event and state flags
  typedef struct packed {
    logic       doze_entry_flag;
    logic       doze_exit_flag;
    logic [2:0] error_type_field;
    logic       error_type_hw_wr;
    logic       error_passive_indication;
    logic       error_warning_indication;
    logic [8:0] transmit_error_count;
    logic       fifo1_overflow_flag;
    logic [1:0] fifo1_msg_count;
    logic       fifo0_overflow_flag;
    logic [1:0] fifo0_msg_count;
    logic [2:0] mailbox_tx_complete_flag;
  } cie_evt_s;
endpackage

/* cie_rw1c_bit.sv */
// sticky flag with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module cie_rw1c_bit (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output var  logic q
);
  // set beats clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* cie_intc_model.sv */
// interrupt controller model that samples the request lines
`timescale 1ns/1ps
`default_nettype none
module cie_intc_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [9:0]  irq_req,
  input  wire logic        irq,
  output var  logic [10:0] seen
);
  // level capture each cycle, no edge memory
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= 11'h000;
    end else begin
      seen <= {irq, irq_req};
    end
  end
endmodule
`default_nettype wire

/* can_interrupt_enable_gating_tb_top.sv */
// self-checking bench for the can interrupt gating block
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_enable_gating_tb_top;
  import cie_pkg::*;
  logic        clk, reset_n, wr_en, rd_en, smp, rd_q, smp_q;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, v, n;
  logic [9:0]  irq_req;
  logic        irq;
  logic [10:0] seen;
  cie_evt_s    evt;
  logic [31:0] notes[$];
  int          errors, checks_done, cyc;
  int          bpos[10] = '{CIE_B_TXE, CIE_B_F0MSG, CIE_B_F0FU, CIE_B_F0OV, CIE_B_F1MSG,
                            CIE_B_F1FU, CIE_B_F1OV, CIE_B_ERR, CIE_B_DZ_OUT, CIE_B_DZ_IN};
  int          ebit[4] = '{CIE_B_ETR, CIE_B_BOFF, CIE_B_EPAS, CIE_B_EWARN};

  cie_gate DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
                .rd_en(rd_en), .rdata(rdata), .evt(evt), .irq_req(irq_req), .irq(irq));
  cie_intc_model u_intc (.clk(clk), .reset_n(reset_n), .irq_req(irq_req), .irq(irq), .seen(seen));

  // clock generation
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0 && notes.size() == 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watcher: oldest note against read data or sampled requests
  always @(posedge clk) begin
    if (rd_q || smp_q) begin
      n = notes.pop_front();
      checks_done++;
      if ((rd_q && rdata !== n) || (smp_q && {21'h0, seen} !== n)) begin
        errors++;
        $display("ERROR %0t: got %h/%h expected %h", $time, rdata, seen, n);
      end
    end
    rd_q <= rd_en;
    smp_q <= smp;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back(e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic chk(input logic [10:0] e);
    tick(3);
    notes.push_back({21'h0, e});
    @(posedge clk);
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
  endtask

  // drive the flag behind request k
  task automatic cond(input int k, input logic on);
    @(posedge clk);
    case (k)
      0: evt.mailbox_tx_complete_flag <= on ? 3'(xs() % 7 + 1) : 3'h0;
      1: evt.fifo0_msg_count <= on ? 2'h1 : 2'h0;
      2: evt.fifo0_msg_count <= on ? 2'h3 : 2'h0;
      3: evt.fifo0_overflow_flag <= on;
      4: evt.fifo1_msg_count <= on ? 2'h2 : 2'h0;
      5: evt.fifo1_msg_count <= on ? 2'h3 : 2'h0;
      6: evt.fifo1_overflow_flag <= on;
      8: evt.doze_exit_flag <= on;
      default: evt.doze_entry_flag <= on;
    endcase
  endtask

  // drive one error source; bus-off idles at the 255 boundary
  task automatic err_cause(input int s, input logic on);
    @(posedge clk);
    case (s)
      0: begin
        evt.error_type_hw_wr <= on;
        evt.error_type_field <= on ? 3'(xs() % 7 + 1) : CIE_ETR_NONE;
      end
      1: evt.transmit_error_count <= on ? 9'h100 : CIE_BOFF_LIMIT;
      2: evt.error_passive_indication <= on;
      default: evt.error_warning_indication <= on;
    endcase
  endtask

  // main sequence
  initial begin
    seed = 32'h72923A72;
    evt = '0;
    {wr_en, rd_en, smp} = 3'h0;
    addr = 8'h00;
    wdata = 32'h0;
    reset_n = 1'b0;
    tick(8);
    reset_n <= 1'b1;
    tick(4);
    rd(CIE_ENABLE_OFS, CIE_ENABLE_RST);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    repeat (4) begin
      v = xs() & CIE_ENABLE_WMASK;
      wr(CIE_ENABLE_OFS, v);
      rd(CIE_ENABLE_OFS, v);
    end
    wr(CIE_ENABLE_OFS, 32'h0);
    for (int k = 0; k < 10; k++) begin
      if (k != 7) begin
        cond(k, 1'b1);
        chk(11'h000);
        wr(CIE_ENABLE_OFS, 32'h1 << bpos[k]);
        chk(11'h001 << k);
        cond(k, 1'b0);
        wr(CIE_FLAGS_OFS, 32'h6);
        chk(11'h000);
        wr(CIE_ENABLE_OFS, 32'h0);
      end
    end
    for (int s = 0; s < 4; s++) begin
      wr(CIE_ENABLE_OFS, 32'h1 << CIE_B_ERR);
      err_cause(s, 1'b1);
      chk(11'h000);
      err_cause(s, 1'b0);
      wr(CIE_ENABLE_OFS, (32'h1 << CIE_B_ERR) | (32'h1 << ebit[s]));
      err_cause(s, 1'b1);
      chk(11'h080);
      if (s == 1) begin
        rd(CIE_FLAGS_OFS, 32'h9);
      end
      err_cause(s, 1'b0);
      chk(11'h080);
      rd(CIE_FLAGS_OFS, 32'h1);
      wr(CIE_FLAGS_OFS, 32'h1);
      chk(11'h000);
    end
    wr(CIE_STATUS_OFS, 32'h3FF);
    rd(CIE_STATUS_OFS, 32'h0);
    wr(CIE_MASK_OFS, 32'h1);
    wr(CIE_ENABLE_OFS, 32'h1);
    cond(0, 1'b1);
    chk(11'h401);
    rd(CIE_STATUS_OFS, 32'h1);
    wr(CIE_MASK_OFS, 32'h0);
    chk(11'h001);
    wr(CIE_MASK_OFS, 32'h1);
    cond(0, 1'b0);
    chk(11'h400);
    wr(CIE_STATUS_OFS, 32'h1);
    chk(11'h000);
    // mid-run reset must bring the enables back to zero
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(4);
    rd(CIE_ENABLE_OFS, CIE_ENABLE_RST);
    chk(11'h000);
    // let the watcher take the last notes
    tick(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
